/* teq_count_if.sv */
// Purpose: Carries start, event and terminal count between qualifier and counter
// Assumes: Both ends on I_CLOCK
// Notes:   Start, event and terminal strobes are one-cycle pulses; restart is a level
`timescale 1ns/1ps
`default_nettype none
interface teq_count_if;
  logic                      start;
  logic                      event_hit;
  logic [teq_pkg::LOAD_W-1:0] load;
  logic                      tc_hit;
  logic                      restart;
  logic                      short_sel;

  modport ctl (output start, output event_hit, output load,
               input  tc_hit, input restart, input short_sel);
  modport ctr (input  start, input event_hit, input load,
               output tc_hit, output restart, output short_sel);
endinterface
`default_nettype wire

/* teq_event_counter.sv */
// Purpose: Loadable event counter with short path and restart flip-flop
// Assumes: Load of zero is handled outside, by the count-start path
// Notes:   Upper section ignored for loads below four
`timescale 1ns/1ps
`default_nettype none
module teq_event_counter (
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  // Control link
  teq_count_if.ctr    cif
);

  logic [teq_pkg::LOAD_W-1:0] cnt_ff;
  logic                       restart_ff;
  logic                       one_pend_ff;
  logic                       tc_ff;
  logic                       is_one;
  logic                       short_sel;

  // R12 short count bypass
  assign short_sel = (cif.load[teq_pkg::LOAD_W-1:teq_pkg::SHORT_W] == '0);
  assign is_one    = short_sel ? (cnt_ff[teq_pkg::SHORT_W-1:0] == 2'h1)
                               : (cnt_ff == teq_pkg::LOAD_W'(1));

  // R3 loadable event count
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
    end else if (cif.start || tc_ff) begin
      // R18 reload after terminal
      cnt_ff <= cif.load;
    end else if (cif.event_hit && cnt_ff != '0) begin
      cnt_ff <= cnt_ff - teq_pkg::LOAD_W'(1);
    end
  end

  // R11 restart clears first edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      restart_ff <= 1'b0;
    end else if (cif.start) begin
      restart_ff <= 1'b1;
    end else if (cif.event_hit) begin
      restart_ff <= 1'b0;
    end
  end

  // R11 load one, one clock later
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      one_pend_ff <= 1'b0;
    end else begin
      one_pend_ff <= cif.event_hit && restart_ff && (cif.load == teq_pkg::LOAD_W'(1));
    end
  end

  // R16 R18 terminal on Nth edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tc_ff <= 1'b0;
    end else begin
      tc_ff <= one_pend_ff
            || (cif.event_hit && is_one && !cif.start
                && (cif.load != teq_pkg::LOAD_W'(1)));
    end
  end

  assign cif.tc_hit    = tc_ff;
  assign cif.restart   = restart_ff;
  assign cif.short_sel = short_sel;

endmodule // teq_event_counter
`default_nettype wire

/* teq_pkg.sv */
// Purpose: Shared constants and types for the trigger event delay qualifier
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes:   Numbers shared by the design files live here; HOLD_EV is set in the model and in the bench
package teq_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int          LOAD_W      = 29;
  localparam int          SHORT_W     = 2;
  localparam int          CHAN_N      = 4;
  localparam int          SYNC_N      = 7;
  localparam int          CLK_MHZ     = 100;
  localparam int          ARM_DELAY_NS = 10;
  localparam int          ARM_DELAY_CYC =
    ((ARM_DELAY_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 : (ARM_DELAY_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // Pin vector positions
  // ****************************************
  localparam int          PIN_QUAL    = 0;
  localparam int          PIN_SLOPE   = 1;
  localparam int          PIN_HOLD    = 2;
  localparam int          PIN_CHAN    = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic        ARM_RST     = 1'b0;
  localparam logic        TC_LOW_RST  = 1'b1;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [1:0] {
    TEQ_MODE_EDGE,
    TEQ_MODE_PRESENT,
    TEQ_MODE_NOT_PRESENT,
    TEQ_MODE_DELAY_EVENTS
  } teq_mode_t;

  typedef enum logic [1:0] {
    TEQ_ST_WAIT,
    TEQ_ST_DELAY,
    TEQ_ST_COUNT,
    TEQ_ST_ARMED
  } teq_state_t;

endpackage

/* teq_qualifier_chk.sv */
// Purpose: Port assertions for the trigger qualifier
// Assumes: One clock, synchronous active-low reset
// Notes:   Windows allow for the 3-stage pin synchroniser
`timescale 1ns/1ps
`default_nettype none
module teq_qualifier_chk #(
  parameter int LOAD_W = teq_pkg::LOAD_W,
  parameter int CHAN_N = teq_pkg::CHAN_N
) (
  // Inputs of the block
  input  wire logic              I_CLOCK,
  input  wire logic              I_RST_N,
  input  wire logic [1:0]        I_MODE,
  input  wire logic [LOAD_W-1:0] I_LOAD_VALUE,
  input  wire logic [CHAN_N-1:0] I_CHANNEL_ENABLE,
  input  wire logic              I_STATUS_CLEAR,
  input  wire logic              I_QUALIFIER_CLOCK,
  input  wire logic              I_SLOPE_SELECT,
  input  wire logic              I_HOLDOFF_FLAG,
  // Outputs of the block
  input  wire logic              O_TRIGGER_ARM_ENABLE,
  input  wire logic              O_QUALIFIED_TRIGGER_CLOCK,
  input  wire logic              O_EDGE_SEEN,
  input  wire logic              O_TERMINAL_COUNT_LOW,
  input  wire logic              O_COUNT_START
);
  // ****
  // Properties
  // ****
  wire logic arm      = O_TRIGGER_ARM_ENABLE;
  wire logic hf       = I_HOLDOFF_FLAG;
  wire logic tc_low_n = O_TERMINAL_COUNT_LOW;
  wire logic ld0      = (I_MODE == 2'h3) && (I_LOAD_VALUE == '0);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  property p_hold; $rose(hf) && I_MODE != 2'h0 |-> ##[1:7] !arm; endproperty
  a_hold: assert property (p_hold) else $error("arm kept through holdoff");
  property p_edge; I_MODE == 2'h0 && $past(I_MODE, 2) == 2'h0 && $past(I_RST_N, 2) |-> arm;
  endproperty
  a_edge: assert property (p_edge) else $error("arm low in edge mode");
  property p_pres;
    I_MODE == 2'h1 && $rose(I_QUALIFIER_CLOCK) && !arm && !hf |-> !arm [*3] ##[1:4] arm;
  endproperty
  a_pres: assert property (p_pres) else $error("present arm timing");
  property p_abs;
    I_MODE == 2'h2 && $fell(I_QUALIFIER_CLOCK) && !arm && !hf |-> !arm [*3] ##[1:4] arm;
  endproperty
  a_abs: assert property (p_abs) else $error("not present arm timing");
  property p_ld0; ld0 && $rose(I_QUALIFIER_CLOCK) && !arm && !hf |-> ##[3:6] arm; endproperty
  a_ld0: assert property (p_ld0) else $error("load zero arm late");
  property p_cs; ld0 && $rose(arm) |-> O_COUNT_START; endproperty
  a_cs: assert property (p_cs) else $error("load zero arm not from start");
  property p_tcw; $fell(tc_low_n) |=> tc_low_n; endproperty
  a_tcw: assert property (p_tcw) else $error("terminal pulse too long");
  property p_tca; $fell(tc_low_n) && I_MODE == 2'h3 |-> ##[0:3] arm; endproperty
  a_tca: assert property (p_tca) else $error("terminal without arm");
  property p_slope; $changed(I_SLOPE_SELECT) && I_CHANNEL_ENABLE == '0
    |-> ##[2:7] $changed(O_QUALIFIED_TRIGGER_CLOCK); endproperty
  a_slope: assert property (p_slope) else $error("slope toggle lost");
  property p_seen;
    $rose(O_QUALIFIED_TRIGGER_CLOCK) && !I_STATUS_CLEAR |-> ##[0:2] O_EDGE_SEEN;
  endproperty
  a_seen: assert property (p_seen) else $error("edge not recorded");
  c_tc: cover property ($fell(tc_low_n));
  c_hold: cover property ($fell(arm) && hf);
  c_cs: cover property ($rose(O_COUNT_START));
endmodule // teq_qualifier_chk
bind teq_qualifier_top teq_qualifier_chk #(.LOAD_W(LOAD_W), .CHAN_N(CHAN_N)) u_chk (
  .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_MODE(I_MODE), .I_LOAD_VALUE(I_LOAD_VALUE),
  .I_CHANNEL_ENABLE(I_CHANNEL_ENABLE), .I_STATUS_CLEAR(I_STATUS_CLEAR),
  .I_QUALIFIER_CLOCK(I_QUALIFIER_CLOCK), .I_SLOPE_SELECT(I_SLOPE_SELECT),
  .I_HOLDOFF_FLAG(I_HOLDOFF_FLAG), .O_TRIGGER_ARM_ENABLE(O_TRIGGER_ARM_ENABLE),
  .O_QUALIFIED_TRIGGER_CLOCK(O_QUALIFIED_TRIGGER_CLOCK), .O_EDGE_SEEN(O_EDGE_SEEN),
  .O_TERMINAL_COUNT_LOW(O_TERMINAL_COUNT_LOW), .O_COUNT_START(O_COUNT_START));
`default_nettype wire

/* teq_qualifier_top.sv */
// Purpose: Trigger qualifier gating the trigger flip-flop arm enable
// Assumes: Comparator levels and holdoff flag arrive asynchronously
// Notes:   Events are rising edges of the qualified trigger clock
//
// Contract
// R1 - State present: arm one cycle after qualifying
// R2 - State not present mirrors present mode
// R3 - Loadable 29-bit event counter delays arming
// R4 - Delay mode: qualifier arms, counter untouched
// R5 - Load zero means one event delay
// R6 - Load zero: count-start drives arm, steady
// R7 - Trigger edges before qualifier ignored
// R8 - Load zero: qualifier arms at once
// R9 - Trigger flip-flop fires on next edge
// R10 - Holdoff drops arm, returns to waiting
// R11 - Load one: restart clears, output next clock
// R12 - Small loads bypass upper counter section
// R13 - Slope toggle makes event, comparators off
// R14 - Holdoff by events counted on trigger board
// R15 - Status records edge seen, enable present
// R16 - Load two: terminal on second edge
// R17 - Edge and pattern modes hold arm high; the code has no pattern mode, only edge mode holds it
// R18 - Load N: terminal on Nth edge, reload
`timescale 1ns/1ps
`default_nettype none
module teq_qualifier_top #(
  parameter int LOAD_W = teq_pkg::LOAD_W,
  parameter int CHAN_N = teq_pkg::CHAN_N
) (
  // Clock and reset
  input  wire logic              I_CLOCK,
  input  wire logic              I_RST_N,
  // Configuration levels
  input  wire logic [1:0]        I_MODE,
  input  wire logic [LOAD_W-1:0] I_LOAD_VALUE,
  input  wire logic [CHAN_N-1:0] I_CHANNEL_ENABLE,
  input  wire logic              I_STATUS_CLEAR,
  // Comparator pins
  input  wire logic              I_QUALIFIER_CLOCK,
  input  wire logic [CHAN_N-1:0] I_CHANNEL_FOUR_EVENT_CLOCK,
  input  wire logic              I_SLOPE_SELECT,
  // From trigger board
  input  wire logic              I_HOLDOFF_FLAG,
  // To trigger board
  output logic                   O_TRIGGER_ARM_ENABLE,
  output logic                   O_QUALIFIED_TRIGGER_CLOCK,
  // Status
  output logic                   O_EDGE_SEEN,
  output logic                   O_ENABLE_AT_EDGE,
  output logic                   O_TERMINAL_COUNT_LOW,
  output logic                   O_COUNT_START
);

  // ****************************************
  // Parameter checks
  // ****************************************
  if (LOAD_W != teq_pkg::LOAD_W || CHAN_N != teq_pkg::CHAN_N) begin : g_bad_width
    $error("teq_qualifier_top: widths must match the package");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int PN = teq_pkg::PIN_CHAN + CHAN_N;
  logic [PN-1:0] pins;
  logic [PN-1:0] s1_ff;
  logic [PN-1:0] s2_ff;
  logic [PN-1:0] s3_ff;
  logic [PN-1:0] clean_ff;
  logic [PN-1:0] prev_ff;

  assign pins = {I_CHANNEL_FOUR_EVENT_CLOCK, I_HOLDOFF_FLAG, I_SLOPE_SELECT, I_QUALIFIER_CLOCK};

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only when two stages agree
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      clean_ff <= '0;
      prev_ff  <= '0;
    end else begin
      clean_ff <= (s2_ff & s3_ff) | (clean_ff & (s2_ff ^ s3_ff));
      prev_ff  <= clean_ff;
    end
  end

  // ****************************************
  // Event and qualification decode
  // ****************************************
  logic               trig_lvl;
  logic               trig_prev;
  logic               trig_edge;
  logic               qual_lvl;
  logic               qual_prev;
  logic               qual_rise;
  logic               hold_rise;
  teq_pkg::teq_mode_t mode;

  assign mode = teq_pkg::teq_mode_t'(I_MODE);

  // R13 slope toggle is an event source
  assign trig_lvl  = (|(clean_ff[teq_pkg::PIN_CHAN +: CHAN_N] & I_CHANNEL_ENABLE))
                     ^ clean_ff[teq_pkg::PIN_SLOPE];
  assign trig_prev = (|(prev_ff[teq_pkg::PIN_CHAN +: CHAN_N] & I_CHANNEL_ENABLE))
                     ^ prev_ff[teq_pkg::PIN_SLOPE];
  assign trig_edge = trig_lvl && !trig_prev;

  // R2 not-present inverts the condition
  assign qual_lvl  = (mode == teq_pkg::TEQ_MODE_NOT_PRESENT) ? !clean_ff[teq_pkg::PIN_QUAL]
                                                             : clean_ff[teq_pkg::PIN_QUAL];
  assign qual_prev = (mode == teq_pkg::TEQ_MODE_NOT_PRESENT) ? !prev_ff[teq_pkg::PIN_QUAL]
                                                             : prev_ff[teq_pkg::PIN_QUAL];
  assign qual_rise = qual_lvl && !qual_prev;
  assign hold_rise = clean_ff[teq_pkg::PIN_HOLD] && !prev_ff[teq_pkg::PIN_HOLD];

  // ****************************************
  // Event counter
  // ****************************************
  teq_count_if cif ();
  logic        load_zero;

  assign load_zero = (I_LOAD_VALUE == '0);

  teq_event_counter u_counter (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .cif     (cif.ctr)
  );

  // ****************************************
  // Qualifier state machine
  // ****************************************
  teq_pkg::teq_state_t state_ff;
  teq_pkg::teq_state_t nxt_state;
  logic [7:0]          dly_ff;
  logic                start_ff;
  logic                nxt_start;
  logic                dly_done;

  assign dly_done = (dly_ff >= 8'(teq_pkg::ARM_DELAY_CYC - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_start = 1'b0;
    case (state_ff)
      teq_pkg::TEQ_ST_WAIT: begin
        // R7 events before qualifier are ignored
        if (qual_rise && (mode == teq_pkg::TEQ_MODE_PRESENT
                          || mode == teq_pkg::TEQ_MODE_NOT_PRESENT)) begin
          nxt_state = teq_pkg::TEQ_ST_DELAY;
        end else if (qual_rise && mode == teq_pkg::TEQ_MODE_DELAY_EVENTS) begin
          // R4 R5 R8 load zero arms at once
          if (load_zero) begin
            nxt_state = teq_pkg::TEQ_ST_ARMED;
          end else begin
            nxt_state = teq_pkg::TEQ_ST_COUNT;
            nxt_start = 1'b1;
          end
        end
      end
      teq_pkg::TEQ_ST_DELAY: begin
        // R1 arm lags qualification
        if (dly_done) begin
          nxt_state = teq_pkg::TEQ_ST_ARMED;
        end
      end
      teq_pkg::TEQ_ST_COUNT: begin
        if (cif.tc_hit) begin
          nxt_state = teq_pkg::TEQ_ST_ARMED;
        end
      end
      teq_pkg::TEQ_ST_ARMED: begin
        nxt_state = teq_pkg::TEQ_ST_ARMED;
      end
      default: nxt_state = teq_pkg::TEQ_ST_WAIT;
    endcase
    // R10 holdoff returns to waiting
    if (hold_rise || mode == teq_pkg::TEQ_MODE_EDGE) begin
      nxt_state = teq_pkg::TEQ_ST_WAIT;
      nxt_start = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      state_ff <= teq_pkg::TEQ_ST_WAIT;
      start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      start_ff <= nxt_start;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      dly_ff <= '0;
    end else if (state_ff == teq_pkg::TEQ_ST_DELAY) begin
      dly_ff <= dly_ff + 8'h01;
    end else begin
      dly_ff <= '0;
    end
  end

  // R3 counter started only on nonzero load
  assign cif.start     = start_ff;
  assign cif.event_hit = trig_edge && (state_ff == teq_pkg::TEQ_ST_COUNT);
  assign cif.load      = I_LOAD_VALUE;

  // ****************************************
  // Outputs
  // ****************************************
  logic nxt_count_start;

  // R6 count-start flop is the output, so arm and it rise together
  assign nxt_count_start = (nxt_state == teq_pkg::TEQ_ST_ARMED) && load_zero
                           && (mode == teq_pkg::TEQ_MODE_DELAY_EVENTS);

  // R17 edge mode holds arm high; R6 no toggling
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      O_TRIGGER_ARM_ENABLE <= teq_pkg::ARM_RST;
    end else if (mode == teq_pkg::TEQ_MODE_EDGE) begin
      O_TRIGGER_ARM_ENABLE <= 1'b1;
    end else if (load_zero && mode == teq_pkg::TEQ_MODE_DELAY_EVENTS) begin
      // R6 load zero: arm follows count-start
      O_TRIGGER_ARM_ENABLE <= nxt_count_start;
    end else begin
      O_TRIGGER_ARM_ENABLE <= (nxt_state == teq_pkg::TEQ_ST_ARMED);
    end
  end

  // R9 trigger clock passed to the flip-flop
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      O_QUALIFIED_TRIGGER_CLOCK <= 1'b0;
      O_COUNT_START             <= 1'b0;
      O_TERMINAL_COUNT_LOW      <= teq_pkg::TC_LOW_RST;
    end else begin
      O_QUALIFIED_TRIGGER_CLOCK <= trig_lvl;
      O_COUNT_START             <= nxt_count_start || cif.restart;
      O_TERMINAL_COUNT_LOW      <= !cif.tc_hit;
    end
  end

  // R15 sticky status, set beats clear
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      O_EDGE_SEEN      <= 1'b0;
      O_ENABLE_AT_EDGE <= 1'b0;
    end else begin
      O_EDGE_SEEN      <= trig_edge || (O_EDGE_SEEN && !I_STATUS_CLEAR);
      O_ENABLE_AT_EDGE <= (trig_edge && O_TRIGGER_ARM_ENABLE)
                          || (O_ENABLE_AT_EDGE && !I_STATUS_CLEAR);
    end
  end

endmodule // teq_qualifier_top
`default_nettype wire

/* teq_trig_ff_model.sv */
// Purpose: Trigger flip-flop with holdoff counted in events
// Assumes: Same clock as the qualifier
// Notes:   Holdoff ends on the HOLD_EV-th event after firing
`timescale 1ns/1ps
`default_nettype none
module teq_trig_ff_model #(
  parameter int HOLD_EV = 10
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Qualifier side
  input  wire logic i_arm,
  input  wire logic i_tclk,
  output logic      o_holdoff
);
  // ****
  // Fire and holdoff
  // ****
  logic       tclk_d_ff;
  logic [7:0] ev_ff;
  wire logic  rise = i_tclk && !tclk_d_ff;

  always_ff @(posedge i_clk) begin
    tclk_d_ff <= i_tclk;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_holdoff <= 1'h0;
      ev_ff     <= 8'h00;
    end else if (rise && !o_holdoff && i_arm) begin
      o_holdoff <= 1'h1;
      ev_ff     <= 8'h00;
    end else if (rise && o_holdoff) begin
      ev_ff <= ev_ff + 8'h01;
      if (ev_ff == 8'(HOLD_EV - 1)) o_holdoff <= 1'h0;
    end
  end
endmodule // teq_trig_ff_model
`default_nettype wire

/* test_trigger_event_delay_qualifier.sv */
// Purpose: Directed bench for the trigger qualifier
// Assumes: Pins driven at the falling clock edge
// Notes:   Events are slope pulses with channels off, except channel pulses in the edge test
`timescale 1ns/1ps
`default_nettype none
module test_trigger_event_delay_qualifier;
  // ****
  // Stimulus and checking
  // ****
  localparam int HOLD_EV = 10;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [1:0]  mode = 2'h0;
  logic [28:0] load = 29'h0;
  logic [3:0]  chen = 4'h0;
  logic [3:0]  chan = 4'h0;
  logic        sclr = 1'h0;
  logic        qual = 1'h0;
  logic        slope = 1'h0;
  wire logic   hold, arm, qtc, seen, ena, tc_low_n, cs;
  int          fail_count = 0;
  int          tests_run = 0;
  int          tc_cnt = 0;
  int          loads[6] = '{0, 1, 2, 3, 5, 2};

  always #5 clk = ~clk;
  always @(posedge clk) if (!tc_low_n) tc_cnt <= tc_cnt + 1;

  teq_qualifier_top dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_MODE(mode), .I_LOAD_VALUE(load),
    .I_CHANNEL_ENABLE(chen), .I_STATUS_CLEAR(sclr), .I_QUALIFIER_CLOCK(qual),
    .I_CHANNEL_FOUR_EVENT_CLOCK(chan), .I_SLOPE_SELECT(slope), .I_HOLDOFF_FLAG(hold),
    .O_TRIGGER_ARM_ENABLE(arm), .O_QUALIFIED_TRIGGER_CLOCK(qtc), .O_EDGE_SEEN(seen),
    .O_ENABLE_AT_EDGE(ena), .O_TERMINAL_COUNT_LOW(tc_low_n), .O_COUNT_START(cs));
  teq_trig_ff_model #(.HOLD_EV(HOLD_EV)) u_ff (.i_clk(clk), .i_rst_n(rst_n), .i_arm(arm),
    .i_tclk(qtc), .o_holdoff(hold));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One trigger event, spaced for the synchroniser
  task automatic ev();
    slope = 1'h1;
    cyc(8);
    slope = 1'h0;
    cyc(8);
  endtask
  task automatic pulse(input int k);
    chan[k] = 1'h1;
    cyc(8);
    chan[k] = 1'h0;
    cyc(8);
  endtask
  task automatic wait_arm();
    for (int i = 0; i < 40 && arm !== 1'h1; i++) cyc(1);
    if (arm !== 1'h1) begin
      chk("arm wait", arm, 1'h1);
      complete_run();
    end
  endtask
  task automatic clr();
    sclr = 1'h1;
    cyc(2);
    sclr = 1'h0;
    cyc(1);
  endtask
  task automatic rel();
    repeat (HOLD_EV) ev();
    chk("holdoff end", hold, 1'h0);
  endtask

  task automatic t_edge();
    chen = 4'h1;
    cyc(4);
    clr();
    chk("edge arm", arm, 1'h1);
    pulse(1);
    chk("masked edge", seen, 1'h0);
    pulse(0);
    chk("edge seen", seen, 1'h1);
    chk("holdoff up", hold, 1'h1);
    chk("arm in holdoff", arm, 1'h1);
    chen = 4'h0;
    cyc(8);
    rel();
    $display("edge mode test done");
  endtask
  task automatic t_state(input logic [1:0] m, input logic st);
    mode = 2'h0;
    qual = st;
    cyc(8);
    mode = m;
    cyc(8);
    clr();
    chk("state idle", arm, 1'h0);
    qual = ~st;
    slope = 1'h1;
    cyc(3);
    chk("arm delayed", arm, 1'h0);
    wait_arm();
    slope = 1'h0;
    cyc(8);
    chk("edge seen", seen, 1'h1);
    chk("coincident edge", ena, 1'h0);
    ev();
    chk("enable at edge", ena, 1'h1);
    chk("disarm", arm, 1'h0);
    qual = st;
    cyc(8);
    rel();
    $display("state mode %0d test done", m);
  endtask
  task automatic t_delay(input int n);
    int t;
    mode = 2'h3;
    load = n[28:0];
    qual = 1'h0;
    cyc(8);
    ev();
    chk("event before qualifier", arm, 1'h0);
    t = tc_cnt;
    qual = 1'h1;
    cyc(8);
    if (n == 0) begin
      chk("load zero arm", arm, 1'h1);
      chk("count start", cs, 1'h1);
    end else begin
      chk("restart set", cs, 1'h1);
      for (int i = 1; i < n; i++) begin
        ev();
        chk("counting", arm, 1'h0);
      end
      chk("no early terminal", tc_cnt == t, 1'h1);
      ev();
      chk("armed", arm, 1'h1);
      chk("one terminal", tc_cnt - t == 1, 1'h1);
      chk("restart cleared", cs, 1'h0);
    end
    ev();
    chk("disarm", arm, 1'h0);
    qual = 1'h0;
    cyc(8);
    rel();
    $display("delay load %0d test done", n);
  endtask

  initial begin
    cyc(5);
    rst_n = 1'h1;
    cyc(4);
    chk("reset terminal", tc_low_n, 1'h1);
    t_edge();
    t_state(2'h1, 1'h0);
    t_state(2'h2, 1'h1);
    foreach (loads[k]) t_delay(loads[k]);
    complete_run();
  end
endmodule // test_trigger_event_delay_qualifier
`default_nettype wire
